// [verilog/tmpal_pkg.sv]
/*
 * Constants for the temperature alarm and alert block: command codes,
 * reset values, configuration and status bit positions, timing counts.
 * Assumes a 250 MHz core clock and an external SMBus engine and converter.
 */
// What this block does
// - Report rounded, clamped 8-bit two's complement temperature
// - Limit write in standby re-evaluates last result
// - Critical comparison never sets the alert
// - Fan override forces fan full on while critical is latched, outside standby
// - Override keeps stored duty, then returns to it
// - Sample diode fault at each conversion start
// - Fault on anode high, low, tiny differential
// - No fault shown before first conversion
// - Diode fault loads +127 and sets alert
// - Alert latch cleared only by won response
// - Limits, diode fault, pin edges set alert
// - Conversions continue while alert is asserted
// - Alert output is open-drain
// - Same limit cannot re-alert until rewritten
// - Different new condition sets alert again
// - Response byte is address and a one
// - Lost arbitration keeps the alert asserted
// - Command pointer resets to remote temperature
// - One-shot in standby converts once, then standby
// - One-shot ignored while converting
// - One-shot in autoconvert restarts rate timer
// - Factory configuration bit resets to one, readable
// - Compare after conversion and after limit writes
// - Critical latch sets at limit, clears five below
// - Standby stops conversion, fan low; else 2 Hz
// - Critical sense selects output polarity
package tmpal_pkg;
    // Command codes used as register addresses
    localparam logic [7:0] CMD_RD_TEMP = 8'h01;
    localparam logic [7:0] CMD_RD_STAT = 8'h02;
    localparam logic [7:0] CMD_RD_CFG = 8'h03;
    localparam logic [7:0] CMD_RD_HIGH = 8'h07;
    localparam logic [7:0] CMD_RD_LOW = 8'h08;
    localparam logic [7:0] CMD_WR_CFG = 8'h09;
    localparam logic [7:0] CMD_WR_HIGH = 8'h0D;
    localparam logic [7:0] CMD_WR_LOW = 8'h0E;
    localparam logic [7:0] CMD_ONE_SHOT = 8'h0F;
    localparam logic [7:0] CMD_RD_CRIT = 8'h10;
    localparam logic [7:0] CMD_RD_DUTY = 8'h13;
    localparam logic [7:0] CMD_WR_CRIT = 8'h18;
    localparam logic [7:0] CMD_WR_DUTY = 8'h1B;
    // Reset values
    localparam logic [7:0] CMD_PTR_RST = 8'h01;
    localparam logic [7:0] CFG_RST = 8'h02;
    localparam logic [7:0] HIGH_RST = 8'h7F;
    localparam logic [7:0] LOW_RST = 8'hC9;
    localparam logic [7:0] CRIT_RST = 8'h64;
    localparam logic [7:0] DUTY_RST = 8'h00;
    // Configuration bit positions
    localparam int CFG_LIMIT_MASK = 7;
    localparam int CFG_STANDBY = 6;
    localparam int CFG_CRIT_SENSE = 5;
    localparam int CFG_PIN_ONE_MASK = 4;
    localparam int CFG_PIN_TWO_MASK = 3;
    localparam int CFG_FAN_ON = 2;
    localparam int CFG_FACTORY = 1;
    // Status bit positions
    localparam int STAT_HIGH = 4;
    localparam int STAT_LOW = 3;
    localparam int STAT_FAULT = 2;
    localparam int STAT_PIN_TWO = 1;
    localparam int STAT_PIN_ONE = 0;
    // Temperature range, hysteresis, fault reading, fan full scale
    localparam logic signed [7:0] TEMP_MAX = 8'sh7F;
    localparam logic signed [7:0] TEMP_MIN = 8'shBF;
    localparam logic signed [8:0] CRIT_HYST = 9'sh005;
    localparam logic [7:0] FAN_FULL = 8'hFF;
    localparam logic [7:0] FAN_OFF = 8'h00;
    // Alert response read format: address in 7..1, one in bit 0
    localparam logic [6:0] ARA_ADDR = 7'h0C;
    localparam logic ARA_LSB = 1'b1;
    // Conversion rate, 2 Hz
    localparam int CLK_KHZ = 250000;
    localparam int RATE_PERIOD_MS = 500;
    localparam int RATE_CYCLES = RATE_PERIOD_MS * CLK_KHZ;
endpackage : tmpal_pkg

// [verilog/tmpal_alert.sv]
/*
 * Temperature alarm and alert logic: result encoding, limit compares,
 * critical latch and fan override, diode fault, alert latch and the
 * alert response answer, one-shot and autoconvert sequencing.
 * Assumes a converter and an SMBus engine on the same clock; analog
 * comparators, general pins and address straps arrive asynchronously.
 */
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tmpal_alert #(
    parameter int ADC_W = 10,
    parameter int ADC_FRAC = 2,
    parameter int RATE_CYCLES = tmpal_pkg::RATE_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic recv_rd_i,
    output logic [7:0] reg_rdata_o,
    // Alert response from the SMBus engine
    input wire logic ara_req_i,
    input wire logic ara_won_i,
    output logic ara_ack_o,
    output logic [7:0] ara_data_o,
    // Converter
    input wire logic adc_done_i,
    input wire logic signed [ADC_W-1:0] adc_result_i,
    output logic conv_start_o,
    output logic conv_abort_o,
    // Analog fault comparators
    input wire logic anode_high_i,
    input wire logic anode_low_i,
    input wire logic adc_tiny_diff_i,
    // Pins
    input wire logic general_pin_one_i,
    input wire logic general_pin_two_i,
    input wire logic [6:0] slave_address_bits_i,
    output logic alert_out_o,
    output logic alert_oe_o,
    output logic critical_temp_output_o,
    output logic critical_temp_oe_o,
    output logic [7:0] fan_level_o
);

    localparam int SYNC_W = 12;
    localparam int RND_W = ADC_W + 1 - ADC_FRAC;
    localparam logic [31:0] RATE_LAST = 32'(RATE_CYCLES - 1);
    localparam logic signed [ADC_W:0] ROUND_HALF = (ADC_W + 1)'(1 << (ADC_FRAC - 1));

    // Two-flop synchroniser for every asynchronous input
    logic [SYNC_W-1:0] sync1_r, sync2_r, async_in;
    logic [1:0] pin_prev_r;
    assign async_in = {slave_address_bits_i, general_pin_two_i, general_pin_one_i,
                       adc_tiny_diff_i, anode_low_i, anode_high_i};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
            pin_prev_r <= '0;
        end else begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
            pin_prev_r <= sync2_r[4:3];
        end
    end

    logic fault_now;
    logic [1:0] pin_now;
    logic [6:0] own_addr;
    assign fault_now = |sync2_r[2:0];
    assign pin_now = sync2_r[4:3];
    assign own_addr = sync2_r[11:5];

    // Registers written over the port
    logic [7:0] cfg_r, high_r, low_r, crit_r, duty_r, cmd_ptr_r;

    logic wr_cfg, wr_high, wr_low, wr_crit, wr_duty, wr_shot;
    assign wr_cfg = reg_wr_i && (reg_addr_i == tmpal_pkg::CMD_WR_CFG);
    assign wr_high = reg_wr_i && (reg_addr_i == tmpal_pkg::CMD_WR_HIGH);
    assign wr_low = reg_wr_i && (reg_addr_i == tmpal_pkg::CMD_WR_LOW);
    assign wr_crit = reg_wr_i && (reg_addr_i == tmpal_pkg::CMD_WR_CRIT);
    assign wr_duty = reg_wr_i && (reg_addr_i == tmpal_pkg::CMD_WR_DUTY);
    assign wr_shot = reg_wr_i && (reg_addr_i == tmpal_pkg::CMD_ONE_SHOT);

    // Factory bit is stored as written; software is expected to keep it set
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_r <= tmpal_pkg::CFG_RST;
            high_r <= tmpal_pkg::HIGH_RST;
            low_r <= tmpal_pkg::LOW_RST;
            crit_r <= tmpal_pkg::CRIT_RST;
            duty_r <= tmpal_pkg::DUTY_RST;
        end else begin
            if (wr_cfg) begin
                cfg_r <= reg_wdata_i;
            end
            if (wr_high) begin
                high_r <= reg_wdata_i;
            end
            if (wr_low) begin
                low_r <= reg_wdata_i;
            end
            if (wr_crit) begin
                crit_r <= reg_wdata_i;
            end
            if (wr_duty) begin
                duty_r <= reg_wdata_i;
            end
        end
    end

    // Command pointer follows every addressed access
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_ptr_r <= tmpal_pkg::CMD_PTR_RST;
        end else if (reg_wr_i || reg_rd_i) begin
            cmd_ptr_r <= reg_addr_i;
        end
    end

    logic standby;
    assign standby = cfg_r[tmpal_pkg::CFG_STANDBY];

    // Conversion sequencing
    typedef enum logic [2:0] {
        TMPAL_IDLE = 3'b001,
        TMPAL_CONV = 3'b010,
        TMPAL_DONE = 3'b100
    } tmpal_state_t;

    tmpal_state_t state_r;
    logic [31:0] rate_cnt_r;
    logic standby_prev_r, fault_r, start_now, rate_hit;

    assign rate_hit = !standby && (rate_cnt_r == RATE_LAST);
    // Leaving standby starts a conversion at once and restarts the timer
    assign start_now = (state_r == TMPAL_IDLE) &&
                       (wr_shot || rate_hit || (standby_prev_r && !standby));

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= TMPAL_IDLE;
            conv_start_o <= 1'b0;
            conv_abort_o <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            conv_start_o <= 1'b0;
            conv_abort_o <= 1'b0;
            case (state_r)
                TMPAL_IDLE: begin
                    if (start_now) begin
                        state_r <= TMPAL_CONV;
                        conv_start_o <= 1'b1;
                        fault_r <= fault_now;
                    end
                end
                TMPAL_CONV: begin
                    if (standby && !standby_prev_r) begin
                        state_r <= TMPAL_IDLE;
                        conv_abort_o <= 1'b1;
                    end else if (adc_done_i) begin
                        state_r <= TMPAL_DONE;
                    end
                end
                TMPAL_DONE: begin
                    state_r <= TMPAL_IDLE;
                end
                default: begin
                    state_r <= TMPAL_IDLE;
                end
            endcase
        end
    end

    // Rate timer; a one-shot or a standby exit restarts the full period
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rate_cnt_r <= '0;
            standby_prev_r <= 1'b0;
        end else begin
            standby_prev_r <= standby;
            if (standby || start_now) begin
                rate_cnt_r <= '0;
            end else if (!rate_hit) begin
                rate_cnt_r <= rate_cnt_r + 32'h00000001;
            end
        end
    end

    // Round to nearest, halves upward, then clamp
    logic signed [ADC_W:0] adc_sum;
    logic signed [RND_W-1:0] adc_rnd;
    logic signed [7:0] temp_enc;
    assign adc_sum = $signed({adc_result_i[ADC_W-1], adc_result_i}) + ROUND_HALF;
    assign adc_rnd = adc_sum[ADC_W:ADC_FRAC];

    always_comb begin
        if (adc_rnd > RND_W'(tmpal_pkg::TEMP_MAX)) begin
            temp_enc = tmpal_pkg::TEMP_MAX;
        end else if (adc_rnd < RND_W'(tmpal_pkg::TEMP_MIN)) begin
            temp_enc = tmpal_pkg::TEMP_MIN;
        end else begin
            temp_enc = adc_rnd[7:0];
        end
    end

    // Result register keeps updating regardless of the alert line
    logic signed [7:0] temp_r;
    logic valid_r, conv_eval_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            temp_r <= '0;
            valid_r <= 1'b0;
            conv_eval_r <= 1'b0;
        end else begin
            conv_eval_r <= 1'b0;
            if (state_r == TMPAL_CONV && adc_done_i && !(standby && !standby_prev_r)) begin
                temp_r <= fault_r ? tmpal_pkg::TEMP_MAX : temp_enc;
                valid_r <= 1'b1;
                conv_eval_r <= 1'b1;
            end
        end
    end

    // Compare strobes, in the cycle a written limit settles, one cycle after a new result settles
    logic eval_high_r, eval_low_r, eval_crit_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            eval_high_r <= 1'b0;
            eval_low_r <= 1'b0;
            eval_crit_r <= 1'b0;
        end else begin
            eval_high_r <= (wr_high && valid_r) || conv_eval_r;
            eval_low_r <= (wr_low && valid_r) || conv_eval_r;
            eval_crit_r <= (wr_crit && valid_r) || conv_eval_r;
        end
    end

    logic high_hit, low_hit, crit_set, crit_clr;
    assign high_hit = temp_r >= $signed(high_r);
    assign low_hit = temp_r <= $signed(low_r);
    assign crit_set = temp_r >= $signed(crit_r);
    assign crit_clr = $signed({temp_r[7], temp_r}) <=
                      ($signed({crit_r[7], crit_r}) - tmpal_pkg::CRIT_HYST);

    // Critical latch with hysteresis; it feeds no alert path
    logic crit_latch_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            crit_latch_r <= 1'b0;
        end else if (eval_crit_r) begin
            if (crit_set) begin
                crit_latch_r <= 1'b1;
            end else if (crit_clr) begin
                crit_latch_r <= 1'b0;
            end
        end
    end

    // Limit flags and per-limit arming
    logic high_flag_r, low_flag_r, high_armed_r, low_armed_r;
    logic limit_mask, high_evt, low_evt;
    assign limit_mask = cfg_r[tmpal_pkg::CFG_LIMIT_MASK];
    assign high_evt = eval_high_r && high_hit && high_armed_r && !limit_mask;
    assign low_evt = eval_low_r && low_hit && low_armed_r && !limit_mask;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            high_flag_r <= 1'b0;
            low_flag_r <= 1'b0;
            high_armed_r <= 1'b1;
            low_armed_r <= 1'b1;
        end else begin
            if (eval_high_r) begin
                high_flag_r <= high_hit;
            end
            if (eval_low_r) begin
                low_flag_r <= low_hit;
            end
            // A rewrite re-arms even if it races with an event
            if (wr_high) begin
                high_armed_r <= 1'b1;
            end else if (high_evt) begin
                high_armed_r <= 1'b0;
            end
            if (wr_low) begin
                low_armed_r <= 1'b1;
            end else if (low_evt) begin
                low_armed_r <= 1'b0;
            end
        end
    end

    // Alert latch: a set in the clearing cycle wins
    logic fault_evt, pin_evt, alert_set, alert_r;
    logic [1:0] pin_edge;
    assign pin_edge = pin_now ^ pin_prev_r;
    assign fault_evt = start_now && fault_now && !limit_mask;
    assign pin_evt = (pin_edge[0] && !cfg_r[tmpal_pkg::CFG_PIN_ONE_MASK]) ||
                     (pin_edge[1] && !cfg_r[tmpal_pkg::CFG_PIN_TWO_MASK]);
    assign alert_set = high_evt || low_evt || fault_evt || pin_evt;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alert_r <= 1'b0;
        end else begin
            alert_r <= alert_set || (alert_r && !ara_won_i);
        end
    end

    // Open-drain pins: value held low, enable carries the state
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alert_out_o <= 1'b0;
            alert_oe_o <= 1'b0;
            critical_temp_output_o <= 1'b0;
            critical_temp_oe_o <= 1'b0;
        end else begin
            alert_out_o <= 1'b0;
            alert_oe_o <= alert_r;
            critical_temp_output_o <= 1'b0;
            critical_temp_oe_o <= crit_latch_r ^ cfg_r[tmpal_pkg::CFG_CRIT_SENSE];
        end
    end

    // Fan level; override never touches the stored duty
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fan_level_o <= tmpal_pkg::FAN_OFF;
        end else if (standby) begin
            fan_level_o <= tmpal_pkg::FAN_OFF;
        end else if (cfg_r[tmpal_pkg::CFG_FAN_ON] && crit_latch_r) begin
            fan_level_o <= tmpal_pkg::FAN_FULL;
        end else begin
            fan_level_o <= duty_r;
        end
    end

    // Alert response: only a pending device answers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ara_ack_o <= 1'b0;
            ara_data_o <= '0;
        end else begin
            ara_ack_o <= ara_req_i && alert_r;
            if (ara_req_i) begin
                ara_data_o <= {own_addr, tmpal_pkg::ARA_LSB};
            end
        end
    end

    // Read mux; unused codes read zero
    logic [7:0] stat_byte, rd_sel, rd_val;
    always_comb begin
        stat_byte = '0;
        stat_byte[tmpal_pkg::STAT_HIGH] = high_flag_r;
        stat_byte[tmpal_pkg::STAT_LOW] = low_flag_r;
        stat_byte[tmpal_pkg::STAT_FAULT] = fault_r;
        stat_byte[tmpal_pkg::STAT_PIN_TWO] = pin_now[1];
        stat_byte[tmpal_pkg::STAT_PIN_ONE] = pin_now[0];
    end

    assign rd_sel = recv_rd_i ? cmd_ptr_r : reg_addr_i;

    always_comb begin
        case (rd_sel)
            tmpal_pkg::CMD_RD_TEMP: rd_val = temp_r;
            tmpal_pkg::CMD_RD_STAT: rd_val = stat_byte;
            tmpal_pkg::CMD_RD_CFG: rd_val = cfg_r;
            tmpal_pkg::CMD_RD_HIGH: rd_val = high_r;
            tmpal_pkg::CMD_RD_LOW: rd_val = low_r;
            tmpal_pkg::CMD_RD_CRIT: rd_val = crit_r;
            tmpal_pkg::CMD_RD_DUTY: rd_val = duty_r;
            default: rd_val = '0;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i || recv_rd_i) begin
            reg_rdata_o <= rd_val;
        end else begin
            reg_rdata_o <= '0;
        end
    end

endmodule : tmpal_alert
`default_nettype wire

// [tb/tmpal_conv_model.sv]
/*
 * Converter model for the alarm block: answers each start with one
 * done pulse after LAT cycles, carrying the value set by the bench.
 * Assumes the block's clock and reset; abort drops a running conversion.
 */
`timescale 1ns/1ps
`default_nettype none
module tmpal_conv_model #(
    parameter int W = 10,
    parameter int LAT = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Block side
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic signed [W-1:0] value_i,
    output logic done_o,
    output logic signed [W-1:0] result_o
);
    int cnt;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= 0;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt == 1) && !abort_i;
            if (abort_i)
                cnt <= 0;
            else if (start_i)
                cnt <= LAT;
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
    // Outside the pulse the lines carry junk, so a stale read shows up
    assign result_o = done_o ? value_i : ~value_i;
endmodule : tmpal_conv_model
`default_nettype wire

// [tb/tmpal_alert_chk.sv]
/*
 * Port checker for the alarm block, bound to every instance.
 * Assumes one clock domain with asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module tmpal_alert_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Watched ports
    input wire logic reg_rd_i,
    input wire logic recv_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic ara_req_i,
    input wire logic ara_won_i,
    input wire logic ara_ack_o,
    input wire logic [7:0] ara_data_o,
    input wire logic [6:0] slave_address_bits_i,
    input wire logic conv_start_o,
    input wire logic conv_abort_o,
    input wire logic alert_out_o,
    input wire logic alert_oe_o,
    input wire logic critical_temp_output_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_alert_od_drive: assert property (alert_out_o == 1'b0)
        else $error("alert pin driven high");
    a_crit_od_drive: assert property (critical_temp_output_o == 1'b0)
        else $error("critical pin driven high");
    a_ack_after_req: assert property (ara_ack_o |-> $past(ara_req_i))
        else $error("response ack without request");
    a_ack_tracks_alert: assert property (ara_req_i |=> ara_ack_o == alert_oe_o)
        else $error("response ack disagrees with pending alert");
    a_ara_data_fmt: assert property (ara_ack_o |-> ara_data_o == {slave_address_bits_i, 1'b1})
        else $error("response byte malformed");
    a_alert_clear_cause: assert property ($fell(alert_oe_o) |-> $past(ara_won_i, 2))
        else $error("alert released without won response");
    a_rdata_idle: assert property (!$past(reg_rd_i) && !$past(recv_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside read cycle");
    a_abort_no_start: assert property (conv_abort_o |-> !conv_start_o ##1 !conv_start_o)
        else $error("start beside abort");
    c_ack: cover property (ara_ack_o);
    c_alert_clear: cover property ($fell(alert_oe_o));
    c_start: cover property (conv_start_o);
    c_abort: cover property (conv_abort_o);
endmodule : tmpal_alert_chk
bind tmpal_alert tmpal_alert_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .reg_rd_i(reg_rd_i), .recv_rd_i(recv_rd_i), .reg_rdata_o(reg_rdata_o),
    .ara_req_i(ara_req_i), .ara_won_i(ara_won_i), .ara_ack_o(ara_ack_o),
    .ara_data_o(ara_data_o), .slave_address_bits_i(slave_address_bits_i),
    .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
    .alert_out_o(alert_out_o), .alert_oe_o(alert_oe_o),
    .critical_temp_output_o(critical_temp_output_o));
`default_nettype wire

// [tb/tb_top.sv]
/*
 * Bench for the alarm block: register tasks, converter model, tests.
 * Assumes the design's package; the rate count is shortened to RATE.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int RATE = 400;
    logic clk_i = 0;
    logic reset_n_i = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, ara_data, fan, v;
    logic wr = 0, rd = 0, recv = 0, ara_req = 0, ara_won = 0;
    logic hi = 1, lo = 0, tiny = 0, pin1 = 0, pin2 = 0;
    logic signed [9:0] res_q = 0, adc_res;
    logic adc_done, start, abort, ara_ack, al_out, al_oe, cr_out, cr_oe;
    int error_cnt = 0, comparisons = 0, cyc = 0, starts = 0, last = 0, t0, n;
    int tr[9] = '{101, 2, -2, -3, -100, 504, 506, -219, -280};
    logic [7:0] tt[9] = '{8'h19, 8'h01, 8'h00, 8'hFF, 8'hE7, 8'h7E, 8'h7F, 8'hC9, 8'hBF};
    logic ta[9] = '{0, 0, 0, 0, 0, 0, 1, 1, 0};
    logic tc[9] = '{0, 0, 0, 0, 0, 1, 1, 0, 0};
    logic [7:0] ra[6] = '{8'h03, 8'h07, 8'h08, 8'h10, 8'h13, 8'h04};
    logic [7:0] rv[6] = '{8'h02, 8'h7F, 8'hC9, 8'h64, 8'h00, 8'h00};
    tmpal_alert #(.RATE_CYCLES(RATE)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .recv_rd_i(recv), .reg_rdata_o(rdata), .ara_req_i(ara_req), .ara_won_i(ara_won),
        .ara_ack_o(ara_ack), .ara_data_o(ara_data), .adc_done_i(adc_done),
        .adc_result_i(adc_res), .conv_start_o(start), .conv_abort_o(abort),
        .anode_high_i(hi), .anode_low_i(lo), .adc_tiny_diff_i(tiny),
        .general_pin_one_i(pin1), .general_pin_two_i(pin2),
        .slave_address_bits_i(7'h2A), .alert_out_o(al_out), .alert_oe_o(al_oe),
        .critical_temp_output_o(cr_out), .critical_temp_oe_o(cr_oe), .fan_level_o(fan));
    tmpal_conv_model u_conv (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start),
        .abort_i(abort), .value_i(res_q), .done_o(adc_done), .result_o(adc_res));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (start) begin
            starts <= starts + 1;
            last <= cyc;
        end
        // Ceiling well above the thousand or so cycles the tests need
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    task test_done;
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task check(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask : check
    task wait_n(input int k);
        repeat (k) @(posedge clk_i);
    endtask : wait_n
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [7:0] a, input logic r, output logic [7:0] q);
        @(posedge clk_i);
        addr <= a;
        rd <= !r;
        recv <= r;
        @(posedge clk_i);
        rd <= 1'b0;
        recv <= 1'b0;
        @(posedge clk_i);
        q = rdata;
    endtask : rd_reg
    task convert(input int r);
        int i;
        res_q <= 10'(r);
        wr_reg(tmpal_pkg::CMD_ONE_SHOT, 8'h00);
        i = 0;
        while (adc_done !== 1'b1 && i < 100) begin
            @(posedge clk_i);
            i++;
        end
        check("conversion done", i < 100, 1);
        wait_n(4);
    endtask : convert
    task ara_clear;
        @(posedge clk_i);
        ara_req <= 1'b1;
        @(posedge clk_i);
        ara_req <= 1'b0;
        @(posedge clk_i);
        check("ara ack", ara_ack, 1);
        check("ara data", ara_data, {7'h2A, 1'b1});
        wait_n(4);
        check("alert held", al_oe, 1);
        ara_won <= 1'b1;
        @(posedge clk_i);
        ara_won <= 1'b0;
        wait_n(3);
        check("alert cleared", al_oe, 0);
    endtask : ara_clear
    initial begin
        wait_n(20);
        reset_n_i <= 1'b1;
        rd_reg(8'h00, 1, v);
        check("receive byte", v, 8'h00);
        // Broken diode before any conversion must not show
        rd_reg(tmpal_pkg::CMD_RD_STAT, 0, v);
        check("status fault", v[tmpal_pkg::STAT_FAULT], 0);
        // Mend the diode early: it needs two sync stages before a start
        hi <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            rd_reg(ra[k], 0, v);
            check("reset value", v, rv[k]);
        end
        wr_reg(tmpal_pkg::CMD_WR_CFG, 8'h42);
        wr_reg(tmpal_pkg::CMD_WR_DUTY, 8'h40);
        $display("reset test done");
        for (int k = 0; k < 9; k++) begin
            convert(tr[k]);
            rd_reg(tmpal_pkg::CMD_RD_TEMP, 0, v);
            check("temperature", v, tt[k]);
            check("alert", al_oe, ta[k]);
            check("critical", cr_oe, tc[k]);
            if (ta[k])
                ara_clear();
        end
        wr_reg(tmpal_pkg::CMD_WR_LOW, tmpal_pkg::LOW_RST);
        wait_n(4);
        check("alert on rewrite", al_oe, 1);
        ara_clear();
        $display("limit test done");
        for (int k = 0; k < 2; k++) begin
            pin2 <= !pin2;
            wait_n(6);
            check("alert on pin", al_oe, 1);
            ara_clear();
        end
        for (int k = 0; k < 3; k++) begin
            {tiny, lo, hi} <= 3'(1 << k);
            wait_n(3);
            convert(100);
            rd_reg(tmpal_pkg::CMD_RD_TEMP, 0, v);
            check("fault reading", v, 8'h7F);
            rd_reg(tmpal_pkg::CMD_RD_STAT, 0, v);
            check("fault flag", v[tmpal_pkg::STAT_FAULT], 1);
            check("fault alert", al_oe, 1);
            {tiny, lo, hi} <= 3'b000;
            ara_clear();
        end
        $display("fault test done");
        n = starts;
        res_q <= 10'(508);
        wr_reg(tmpal_pkg::CMD_WR_CFG, 8'h06);
        wr_reg(tmpal_pkg::CMD_ONE_SHOT, 8'h00);
        wait_n(20);
        check("starts", starts - n, 1);
        check("fan override", fan, 8'hFF);
        rd_reg(tmpal_pkg::CMD_RD_DUTY, 0, v);
        check("duty kept", v, 8'h40);
        convert(100);
        t0 = last;
        wait_n(4);
        check("fan back", fan, 8'h40);
        res_q <= 10'(200);
        pin1 <= 1'b1;
        n = starts;
        for (int i = 0; i < RATE + 50 && starts == n; i++)
            @(posedge clk_i);
        check("rate restart", last - t0 >= RATE - 2 && last - t0 <= RATE + 2, 1);
        wait_n(16);
        rd_reg(tmpal_pkg::CMD_RD_TEMP, 0, v);
        check("temp under alert", v, 8'h32);
        ara_clear();
        res_q <= 10'(0);
        wr_reg(tmpal_pkg::CMD_ONE_SHOT, 8'h00);
        wr_reg(tmpal_pkg::CMD_WR_CFG, 8'h62);
        wait_n(20);
        check("fan standby", fan, 8'h00);
        check("critical sense", cr_oe, 1);
        rd_reg(tmpal_pkg::CMD_RD_TEMP, 0, v);
        check("temp after abort", v, 8'h32);
        rd_reg(tmpal_pkg::CMD_RD_CFG, 0, v);
        check("config read", v, 8'h62);
        $display("fan test done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
